// [hw/fesb_top.v]
// Framer event status bank: three read-clear status registers
// Assumes a classic Wishbone master on mclk; framer events are mclk-synchronous
`timescale 1ns/10ps
`default_nettype none
`include "fesb_defs.vh"
module fesb_top #(
  parameter DEPTH = `FESB_FIFO_DEPTH
) (
  input wire mclk,
  input wire arst_n,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [`FESB_ADDR_W+1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output wire wb_ack_o,
  input wire [7:0] cnt_err,
  input wire cnt_clr,
  input wire t1_mode,
  input wire tx_bit_tick,
  input wire tx_signaling_mf_tick,
  input wire tx_sysbus_mf_tick,
  input wire tx_multiframe_tick,
  input wire rx_signaling_mf_tick,
  input wire rx_sysbus_mf_tick,
  input wire rx_multiframe_tick,
  input wire rx_frame_tick,
  input wire tx_codeword_sent,
  input wire rx_wr,
  input wire [7:0] rx_wr_data,
  input wire rx_eom,
  input wire tx_rd,
  input wire tx_closing_flag,
  output reg [7:0] tx_out_data,
  output reg tx_abort,
  output reg tx_buffer_half_indicator,
  output wire irq
);
  //////////////////////////////////////////////////////////////////////
  // Bus decode
  reg ack;
  reg [7:0] overflow_irq_enable;
  reg [7:0] timer_irq_enable;
  reg [7:0] link_one_irq_enable;
  reg [5:0] near_full_thr;
  reg [5:0] message_fill_limit;
  reg [5:0] tx_empty_threshold_config;
  reg six_bit_packing_mode;
  reg eight_bit_packing_mode;
  wire [7:0] ovf_stat;
  wire [7:0] tmr_stat;
  wire [7:0] dl1_stat;
  wire req;
  wire wr;
  wire rd;
  wire [`FESB_ADDR_W-1:0] idx;

  function hit;
    input [`FESB_ADDR_W-1:0] a;
    input [`FESB_ADDR_W-1:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  assign req = wb_cyc_i & wb_stb_i & ~ack;
  assign idx = wb_adr_i[`FESB_ADDR_W+1:2];
  assign wr = req & wb_we_i & wb_sel_i[0];
  assign rd = req & ~wb_we_i;
  assign wb_ack_o = ack;

  //////////////////////////////////////////////////////////////////////
  // Error counters and overflow latch
  wire [7:0] at_max;
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_cnt
      localparam CW = (g == 7) ? `FESB_CNT_OOF_W :
                      (g == 6) ? `FESB_CNT_ALIGNMENT_CHANGE_OVERFLOW_W :
                      (g == 5) ? `FESB_CNT_SEF_W :
                      (g == 4) ? `FESB_CNT_PATTERN_BIT_ERROR_OVERFLOW_W :
                      (g == 3) ? `FESB_CNT_FAR_END_BLOCK_ERROR_OVERFLOW_W :
                      (g == 2) ? `FESB_CNT_LCV_W :
                      (g == 1) ? `FESB_CNT_CRC_W : `FESB_CNT_FRAMING_BIT_ERROR_OVERFLOW_W;
      fesb_err_counter #(.W(CW)) u_cnt (
        .mclk(mclk),
        .arst_n(arst_n),
        .err(cnt_err[g]),
        .clr(cnt_clr),
        .count(),
        .at_max(at_max[g])
      );
    end
  endgenerate

  fesb_edge_latch #(.W(8)) u_ovf (
    .mclk(mclk),
    .arst_n(arst_n),
    .src(at_max),
    .qual(overflow_irq_enable),
    .rd_clr(rd && hit(idx, `FESB_OFS_OVF_STAT)),
    .stat(ovf_stat)
  );

  //////////////////////////////////////////////////////////////////////
  // Transmit frame timing
  reg [8:0] bit_cnt;
  reg tx_frame_tick;
  wire [8:0] frame_last;
  assign frame_last = t1_mode ? 9'h0C0 : 9'h0FF;

  // frame start every 193 or 256 bits
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt <= 9'h000;
      tx_frame_tick <= 1'b0;
      tx_buffer_half_indicator <= 1'b0;
    end else begin
      tx_frame_tick <= 1'b0;
      if (tx_bit_tick) begin
        if (bit_cnt == frame_last) begin
          bit_cnt <= 9'h000;
          tx_frame_tick <= 1'b1;
          tx_buffer_half_indicator <= ~tx_buffer_half_indicator;
        end else begin
          bit_cnt <= bit_cnt + 9'h001;
        end
      end
    end
  end

  fesb_edge_latch #(.W(8)) u_tmr (
    .mclk(mclk),
    .arst_n(arst_n),
    .src({tx_signaling_mf_tick, tx_sysbus_mf_tick, tx_multiframe_tick, tx_frame_tick,
          rx_signaling_mf_tick, rx_sysbus_mf_tick, rx_multiframe_tick, rx_frame_tick}),
    .qual(8'hFF),
    .rd_clr(rd && hit(idx, `FESB_OFS_TMR_STAT)),
    .stat(tmr_stat)
  );

  //////////////////////////////////////////////////////////////////////
  // Link one FIFOs
  reg [7:0] rx_mem [0:DEPTH-1];
  reg [7:0] tx_mem [0:DEPTH-1];
  reg [`FESB_FIFO_AW:0] rx_lvl;
  reg [`FESB_FIFO_AW-1:0] rx_wp;
  reg [`FESB_FIFO_AW-1:0] rx_rp;
  reg [`FESB_FIFO_AW:0] tx_lvl;
  reg [`FESB_FIFO_AW-1:0] tx_wp;
  reg [`FESB_FIFO_AW-1:0] tx_rp;
  reg [DEPTH-1:0] tx_eom_mark;
  reg rx_msg_avail;
  wire rx_full;
  wire tx_full;
  wire rx_pop;
  wire tx_push;
  wire tx_pop;
  wire packing;
  wire rx_overrun;
  wire tx_overflow;
  wire tx_underrun;
  wire tx_eom_wr;

  assign rx_full = (rx_lvl == DEPTH);
  assign tx_full = (tx_lvl == DEPTH);
  assign packing = six_bit_packing_mode | eight_bit_packing_mode;
  assign rx_pop = rd && hit(idx, `FESB_OFS_PHASE + 10'h001) && (rx_lvl != 0);
  assign tx_eom_wr = wr && hit(idx, `FESB_OFS_TXLVL + 10'h002);
  assign tx_push = wr && (hit(idx, `FESB_OFS_TXLVL + 10'h001) || tx_eom_wr) && !tx_full;
  // write to full FIFO flagged, data dropped
  assign tx_overflow = wr && (hit(idx, `FESB_OFS_TXLVL + 10'h001) || tx_eom_wr) && tx_full;
  assign tx_pop = tx_rd && (tx_lvl != 0);
  assign tx_underrun = tx_rd && (tx_lvl == 0);
  assign rx_overrun = rx_wr && rx_full;

  always @(posedge mclk) begin
    if (rx_wr && !rx_full) begin
      rx_mem[rx_wp] <= rx_wr_data;
    end
    if (tx_push) begin
      tx_mem[tx_wp] <= wb_dat_i[7:0];
    end
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rx_lvl <= {(`FESB_FIFO_AW+1){1'b0}};
      rx_wp <= {`FESB_FIFO_AW{1'b0}};
      rx_rp <= {`FESB_FIFO_AW{1'b0}};
      tx_lvl <= {(`FESB_FIFO_AW+1){1'b0}};
      tx_wp <= {`FESB_FIFO_AW{1'b0}};
      tx_rp <= {`FESB_FIFO_AW{1'b0}};
      tx_eom_mark <= {DEPTH{1'b0}};
      rx_msg_avail <= 1'b0;
      tx_out_data <= 8'h00;
      tx_abort <= 1'b0;
    end else begin
      if (rx_wr && !rx_full) begin
        rx_wp <= rx_wp + 1'b1;
      end
      if (rx_pop) begin
        rx_rp <= rx_rp + 1'b1;
      end
      rx_lvl <= rx_lvl + ((rx_wr && !rx_full) ? 1'b1 : 1'b0) - (rx_pop ? 1'b1 : 1'b0);
      rx_msg_avail <= ((rx_wr && rx_eom) || rx_msg_avail) && (rx_lvl != 0 || rx_wr);
      if (tx_push) begin
        tx_wp <= tx_wp + 1'b1;
        tx_eom_mark[tx_wp] <= tx_eom_wr;
      end
      if (tx_pop) begin
        tx_rp <= tx_rp + 1'b1;
        tx_out_data <= tx_mem[tx_rp];
        tx_abort <= 1'b0;
      end else if (tx_underrun && !tx_abort) begin
        tx_out_data <= `FESB_ABORT_BYTE;
        tx_abort <= 1'b1;
      end
      tx_lvl <= tx_lvl + (tx_push ? 1'b1 : 1'b0) - (tx_pop ? 1'b1 : 1'b0);
    end
  end

  // Underrun only counts when last byte lacked an end mark
  reg last_eom;
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      last_eom <= 1'b1;
    end else if (tx_pop) begin
      last_eom <= tx_eom_mark[tx_rp];
    end
  end

  wire rx_full_evt;
  wire rx_near_evt;
  wire tx_near_evt;
  assign rx_full_evt = packing ? (rx_lvl >= {1'b0, message_fill_limit}) : rx_overrun;
  assign rx_near_evt = (rx_lvl >= {1'b0, near_full_thr});
  assign tx_near_evt = (tx_lvl < {1'b0, tx_empty_threshold_config});

  fesb_edge_latch #(.W(8)) u_dl1 (
    .mclk(mclk),
    .arst_n(arst_n),
    .src({tx_codeword_sent, rx_full_evt, rx_near_evt, rx_msg_avail,
          tx_underrun & ~last_eom, tx_overflow, tx_near_evt, tx_closing_flag}),
    .qual(8'hFF),
    .rd_clr(rd && hit(idx, `FESB_OFS_DL1_STAT)),
    .stat(dl1_stat)
  );

  assign irq = |(ovf_stat & overflow_irq_enable) | |(tmr_stat & timer_irq_enable) |
               |(dl1_stat & link_one_irq_enable);

  //////////////////////////////////////////////////////////////////////
  // Register writes and read mux
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ack <= 1'b0;
      overflow_irq_enable <= `FESB_IEN_RST;
      timer_irq_enable <= `FESB_IEN_RST;
      link_one_irq_enable <= `FESB_IEN_RST;
      near_full_thr <= `FESB_NEAR_RST;
      message_fill_limit <= `FESB_FILL_RST;
      tx_empty_threshold_config <= `FESB_TXNEAR_RST;
      six_bit_packing_mode <= 1'b0;
      eight_bit_packing_mode <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ack <= req;
      if (wr) begin
        if (hit(idx, `FESB_OFS_OVF_IEN)) overflow_irq_enable <= wb_dat_i[7:0];
        if (hit(idx, `FESB_OFS_TMR_IEN)) timer_irq_enable <= wb_dat_i[7:0];
        if (hit(idx, `FESB_OFS_DL1_IEN)) link_one_irq_enable <= wb_dat_i[7:0];
        if (hit(idx, `FESB_OFS_LEVELS)) near_full_thr <= wb_dat_i[5:0];
        if (hit(idx, `FESB_OFS_LEVELS + 10'h001)) message_fill_limit <= wb_dat_i[5:0];
        if (hit(idx, `FESB_OFS_TXLVL)) tx_empty_threshold_config <= wb_dat_i[5:0];
        if (hit(idx, `FESB_OFS_MODE)) begin
          six_bit_packing_mode <= wb_dat_i[0];
          eight_bit_packing_mode <= wb_dat_i[1];
        end
      end
      wb_dat_o <= 32'h0000_0000;
      if (rd) begin
        case (idx)
          `FESB_OFS_OVF_STAT: wb_dat_o[7:0] <= ovf_stat;
          `FESB_OFS_TMR_STAT: wb_dat_o[7:0] <= tmr_stat;
          `FESB_OFS_DL1_STAT: wb_dat_o[7:0] <= dl1_stat;
          `FESB_OFS_OVF_IEN: wb_dat_o[7:0] <= overflow_irq_enable;
          `FESB_OFS_TMR_IEN: wb_dat_o[7:0] <= timer_irq_enable;
          `FESB_OFS_DL1_IEN: wb_dat_o[7:0] <= link_one_irq_enable;
          `FESB_OFS_LEVELS: wb_dat_o[5:0] <= near_full_thr;
          `FESB_OFS_TXLVL: wb_dat_o[6:0] <= tx_lvl;
          `FESB_OFS_MODE: wb_dat_o[1:0] <= {eight_bit_packing_mode, six_bit_packing_mode};
          `FESB_OFS_PHASE: wb_dat_o[0] <= tx_buffer_half_indicator;
          `FESB_OFS_PHASE + 10'h001: wb_dat_o[7:0] <= rx_mem[rx_rp];
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// [hw/fesb_defs.vh]
// Constants for the framer event status bank
// Assumes inclusion by the bank's design files and its bus checker
`ifndef FESB_DEFS_VH
`define FESB_DEFS_VH

`define FESB_ADDR_W 10
`define FESB_OFS_OVF_STAT 10'h007
`define FESB_OFS_TMR_STAT 10'h008
`define FESB_OFS_DL1_STAT 10'h009
`define FESB_OFS_OVF_IEN 10'h00F
`define FESB_OFS_TMR_IEN 10'h010
`define FESB_OFS_DL1_IEN 10'h011
`define FESB_OFS_LEVELS 10'h0A7
`define FESB_OFS_TXLVL 10'h0AB
`define FESB_OFS_MODE 10'h040
`define FESB_OFS_PHASE 10'h0DC
`define FESB_IEN_RST 8'h00
`define FESB_LVL_RST 8'h00
`define FESB_NEAR_RST 6'h20
`define FESB_FILL_RST 6'h3F
`define FESB_TXNEAR_RST 6'h08
`define FESB_FIFO_DEPTH 64
`define FESB_FIFO_AW 6
`define FESB_BIT_T1 193
`define FESB_BIT_E1 256
`define FESB_CNT_OOF_W 4
`define FESB_CNT_ALIGNMENT_CHANGE_OVERFLOW_W 2
`define FESB_CNT_SEF_W 2
`define FESB_CNT_PATTERN_BIT_ERROR_OVERFLOW_W 12
`define FESB_CNT_FAR_END_BLOCK_ERROR_OVERFLOW_W 10
`define FESB_CNT_LCV_W 16
`define FESB_CNT_CRC_W 10
`define FESB_CNT_FRAMING_BIT_ERROR_OVERFLOW_W 12
`define FESB_ABORT_BYTE 8'h7F

`endif

// [hw/fesb_edge_latch.v]
// Eight rising-edge event latches with read clear
// Assumes event sources synchronous to mclk
`timescale 1ns/10ps
`default_nettype none
module fesb_edge_latch #(
  parameter W = 8
) (
  input wire mclk,
  input wire arst_n,
  input wire [W-1:0] src,
  input wire [W-1:0] qual,
  input wire rd_clr,
  output reg [W-1:0] stat
);
  reg [W-1:0] src_d;
  wire [W-1:0] rise;

  assign rise = src & ~src_d & qual;

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      // Sources high at reset raise no event
      src_d <= {W{1'b1}};
      stat <= {W{1'b0}};
    end else begin
      src_d <= src;
      // Set wins over read clear
      if (rd_clr) begin
        stat <= rise;
      end else begin
        stat <= stat | rise;
      end
    end
  end
endmodule
`default_nettype wire

// [hw/fesb_err_counter.v]
// Saturating error counter with overflow level
// Assumes one-cycle error pulses
`timescale 1ns/10ps
`default_nettype none
module fesb_err_counter #(
  parameter W = 8
) (
  input wire mclk,
  input wire arst_n,
  input wire err,
  input wire clr,
  output reg [W-1:0] count,
  output wire at_max
);
  assign at_max = &count;

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      count <= {W{1'b0}};
    end else if (clr) begin
      count <= {W{1'b0}};
    end else if (err && !at_max) begin
      count <= count + {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule
`default_nettype wire

// [testbench/fesb_props.sv]
// Checker for the framer event status bank bus and transmit outputs
// Assumes binding onto the fesb_top ports in the mclk domain
`timescale 1ns/10ps
`default_nettype none
`include "fesb_defs.vh"
module fesb_props (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`FESB_ADDR_W+1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic t1_mode,
  input wire logic tx_bit_tick,
  input wire logic tx_rd,
  input wire logic [7:0] tx_out_data,
  input wire logic tx_abort,
  input wire logic tx_buffer_half_indicator
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  logic [8:0] ticks;
  logic prev;
  logic seen;
  ////////////////////////////////////////////////////////////////////////////////
  // Bit ticks between two phase toggles
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ticks <= 9'h000;
      prev <= 1'b0;
      seen <= 1'b0;
    end else begin
      prev <= tx_buffer_half_indicator;
      if (tx_buffer_half_indicator != prev) begin
        seen <= 1'b1;
        ticks <= {8'h00, tx_bit_tick};
      end else begin
        ticks <= ticks + {8'h00, tx_bit_tick};
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o))
    else $error("ack without request");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero outside ack");
  a_dat_upper: assert property (wb_dat_o[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  a_frame_len: assert property (seen && tx_buffer_half_indicator != prev |->
    ticks == (t1_mode ? 9'h0c1 : 9'h100)) else $error("frame length wrong");
  a_phase_read: assert property (wb_ack_o && !wb_we_i &&
    wb_adr_i[11:2] == `FESB_OFS_PHASE |-> wb_dat_o[0] == $past(tx_buffer_half_indicator))
    else $error("phase read mismatch");
  a_abort_byte: assert property (tx_abort |-> tx_out_data == `FESB_ABORT_BYTE)
    else $error("abort without abort byte");
  a_abort_cause: assert property ($rose(tx_abort) |-> $past(tx_rd))
    else $error("abort without pull");
endmodule
bind fesb_top fesb_props u_props (.mclk(mclk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .t1_mode(t1_mode), .tx_bit_tick(tx_bit_tick), .tx_rd(tx_rd),
  .tx_out_data(tx_out_data), .tx_abort(tx_abort),
  .tx_buffer_half_indicator(tx_buffer_half_indicator));
`default_nettype wire

// [testbench/tb.sv]
// Self-checking bench for the framer event status bank
// Assumes fesb_top with its default FIFO depth and a 50 MHz mclk
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic mclk = 1'b0, arst_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [3:0] wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [7:0] cnt_err = 8'h00, rx_wr_data = 8'h00, q;
  logic cnt_clr = 1'b0, t1_mode = 1'b0, tx_bit_tick = 1'b0, rx_wr = 1'b0, rx_eom = 1'b0;
  logic tx_rd = 1'b0;
  logic [8:0] ev = 9'h000;
  wire [31:0] wb_dat_o;
  wire [7:0] tx_out_data;
  wire wb_ack_o, tx_abort, tx_buffer_half_indicator, irq;
  int n_errors = 0, comparisons = 0, cycles = 0, i;
  // Status register index, expected byte; row i pulses event input i
  logic [17:0] rows [9] = '{18'h0_0880, 18'h0_0840, 18'h0_0820, 18'h0_0808, 18'h0_0804,
    18'h0_0802, 18'h0_0801, 18'h0_0980, 18'h0_0901};
  fesb_top u_dut (.mclk, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .cnt_err, .cnt_clr, .t1_mode, .tx_bit_tick,
    .tx_signaling_mf_tick(ev[0]), .tx_sysbus_mf_tick(ev[1]), .tx_multiframe_tick(ev[2]),
    .rx_signaling_mf_tick(ev[3]), .rx_sysbus_mf_tick(ev[4]), .rx_multiframe_tick(ev[5]),
    .rx_frame_tick(ev[6]), .tx_codeword_sent(ev[7]), .tx_closing_flag(ev[8]), .rx_wr,
    .rx_wr_data, .rx_eom, .tx_rd, .tx_out_data, .tx_abort, .tx_buffer_half_indicator, .irq);
  ////////////////////////////////////////////////////////////////////////////////
  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 12000) begin
      n_errors = n_errors + 1;
      give_verdict;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task give_verdict;
    $display("Counts: %0d errors, %0d comparisons", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task chk1(input string nm, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask
  task wb(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= {a, 2'b00};
    wb_dat_i <= {24'h00_0000, d};
    @(posedge mclk);
    while (wb_ack_o !== 1'b1) @(posedge mclk);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task rd(input logic [9:0] a, input logic [7:0] m, input logic [7:0] e, input string nm);
    wb(1'b0, a, 8'h00);
    chk8(nm, e, q & m);
  endtask
  task pev(input int k);
    @(posedge mclk) ev[k] <= 1'b1;
    @(posedge mclk) ev[k] <= 1'b0;
  endtask
  task pcnt(input logic [7:0] m, input int n);
    repeat (n) begin
      @(posedge mclk) cnt_err <= m;
      @(posedge mclk) cnt_err <= 8'h00;
    end
  endtask
  task prx(input logic [7:0] d, input logic e);
    @(posedge mclk);
    rx_wr <= 1'b1;
    rx_wr_data <= d;
    rx_eom <= e;
    @(posedge mclk);
    rx_wr <= 1'b0;
    rx_eom <= 1'b0;
  endtask
  task ptx;
    @(posedge mclk) tx_rd <= 1'b1;
    @(posedge mclk) tx_rd <= 1'b0;
  endtask
  task rst;
    arst_n <= 1'b0;
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst;
    rd(10'h007, 8'hff, 8'h00, "ovf_reset");
    rd(10'h3ff, 8'hff, 8'h00, "unmapped");
    wb(1'b1, 10'h3ff, 8'h5a);
    for (i = 0; i < 9; i++) begin
      pev(i);
      rd(rows[i][17:8], 8'hff, rows[i][7:0], "event");
      rd(rows[i][17:8], 8'hff, 8'h00, "cleared");
    end
    wb(1'b1, 10'h00f, 8'ha8);
    pcnt(8'he0, 3);
    pcnt(8'h80, 12);
    pcnt(8'h08, 1023);
    repeat (3) @(negedge mclk);
    chk1("irq_set", 1'b1, irq);
    rd(10'h007, 8'hff, 8'ha8, "ovf");
    chk1("irq_clear", 1'b0, irq);
    rd(10'h007, 8'hff, 8'h00, "ovf_again");
    for (i = 0; i < 65; i++) wb(1'b1, 10'h0ac, i[7:0]);
    rd(10'h009, 8'h04, 8'h04, "tx_over");
    repeat (64) ptx;
    @(negedge mclk) chk8("tx_data", 8'h3f, tx_out_data);
    ptx;
    repeat (2) @(negedge mclk);
    chk1("abort", 1'b1, tx_abort);
    rd(10'h009, 8'h0a, 8'h0a, "tx_under");
    for (i = 0; i < 32; i++) prx(i[7:0], i == 31);
    rd(10'h009, 8'h70, 8'h30, "rx_near");
    for (i = 32; i < 64; i++) prx(i[7:0], 1'b0);
    rd(10'h009, 8'h40, 8'h00, "rx_not_full");
    prx(8'hee, 1'b0);
    rd(10'h009, 8'h40, 8'h40, "rx_full");
    rd(10'h0dd, 8'hff, 8'h00, "rx_head");
    rst;
    wb(1'b1, 10'h040, 8'h01);
    wb(1'b1, 10'h0a8, 8'h04);
    for (i = 0; i < 3; i++) prx(i[7:0], 1'b0);
    rd(10'h009, 8'h40, 8'h00, "pack_below");
    prx(8'h33, 1'b0);
    rd(10'h009, 8'h40, 8'h40, "pack_limit");
    wb(1'b1, 10'h040, 8'h02);
    wb(1'b1, 10'h0a8, 8'h06);
    prx(8'h44, 1'b0);
    rd(10'h009, 8'h40, 8'h00, "eight_bit_packing_mode_below");
    prx(8'h55, 1'b0);
    rd(10'h009, 8'h40, 8'h40, "eight_bit_packing_mode_limit");
    for (i = 0; i < 2; i++) begin
      rst;
      t1_mode <= (i == 0);
      tx_bit_tick <= 1'b1;
      repeat (500 + 300 * i) @(posedge mclk);
      tx_bit_tick <= 1'b0;
      rd(10'h008, 8'h10, 8'h10, "frame");
      rd(10'h0dc, 8'h01, (i == 1) ? 8'h01 : 8'h00, "phase");
    end
    give_verdict;
  end
endmodule
`default_nettype wire
